// [verilog/clock_config_interrupt_regs.sv]
// clock configuration and interrupt registers with peripheral resets.
// assumes oscillator status and low-power events arrive asynchronously;
// register port is a plain strobe port on clk_sys.
//
// Operation
// RL1: control bit 19 enables the clock failure monitor, read-write.
// RL2: pll enable cleared on stop/standby; no clear while pll selected.
// RL3: read-only pll lock flag at bit 25 follows pll lock.
// RL4: select 00 fast internal, 01 fast external, 10 pll, 11 reserved.
// RL5: force fast internal on wake or monitored external failure.
// RL6: status bits 3:2 report the active system clock source.
// RL7: configuration accesses stall one or two cycles during a switch.
// RL8: ahb divider 0xxx none, 1000..1101 by 2..128, 1111 by 256.
// RL9: apb divider 0xx none, 100..111 by 2,4,8,16.
// RL10: pll input select bit 16 changes only while pll disabled.
// RL11: pll multiplier bits 21:18 code plus two, max sixteen, pll off; here codes 14,15 give factor 0, max fifteen.
// RL12: software keeps pll output at or below the maximum frequency.
// RL13: clock output select bits 26:24 choose the output clock source.
// RL14: ready flags 0..5 set when source stable and enable set.
// RL15: failure flag bit 7 set on failure, cleared via bit 23.
// RL16: bits 8..13 enable the ready interrupts in flag order.
// RL17: write one to bits 16..21 clears the matching ready flag.
// RL18: high reset register bits 0,9,11,12,14,16,22 reset peripherals.
// RL19: low reset register bits 0,1,4 reset timers 2,3,6.
// RL20: failure raises the failure interrupt and nmi until cleared.
// RL21: software waits for target source ready before switching.
// RL22: peripheral held in reset while its reset bit reads one.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module clock_config_interrupt_regs (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic reg_wait,
  input wire clock_ctrl_pkg::osc_status_type osc_status,
  input wire logic fast_external_fail,
  input wire logic low_power_entry,
  input wire logic low_power_wake,
  output clock_ctrl_pkg::clock_tree_ctrl_type tree_ctrl,
  output logic [8:0] ahb_divide_log2,
  output logic [4:0] apb_divide_log2,
  output logic [3:0] pll_factor,
  output logic clock_irq,
  output logic nmi_request,
  output logic [31:0] apb_high_reset,
  output logic [31:0] apb_low_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [8:0] async_meta_r;
  logic [8:0] async_sync_r;
  logic fail_prev_r;
  logic entry_prev_r;
  logic wake_prev_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      async_meta_r <= 9'h000;
      async_sync_r <= 9'h000;
    end else begin
      async_meta_r <= {low_power_wake, low_power_entry, fast_external_fail,
                       osc_status};
      async_sync_r <= async_meta_r;
    end
  end

  wire [5:0] ready_sync = async_sync_r[5:0];
  wire fail_sync = async_sync_r[6];
  wire entry_sync = async_sync_r[7];
  wire wake_sync = async_sync_r[8];
  wire pll_locked = ready_sync[4];
  wire fail_rise = fail_sync & ~fail_prev_r;
  wire entry_rise = entry_sync & ~entry_prev_r;
  wire wake_rise = wake_sync & ~wake_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire sel_ctrl = (reg_addr == clock_ctrl_pkg::clock_control_one_offset);
  wire sel_cfg = (reg_addr == clock_ctrl_pkg::clock_configuration_one_offset);
  wire sel_int = (reg_addr == clock_ctrl_pkg::clock_interrupt_control_offset);
  wire sel_hrst = (reg_addr ==
                   clock_ctrl_pkg::apb_high_peripheral_reset_offset);
  wire sel_lrst = (reg_addr ==
                   clock_ctrl_pkg::apb_low_peripheral_reset_offset);

  wire switch_busy;
  wire [1:0] active_source;
  wire cfg_stall = sel_cfg & (reg_write | reg_read) & switch_busy;
  assign reg_wait = cfg_stall; // RL7
  wire wr_ctrl = reg_write & sel_ctrl;
  wire wr_cfg = reg_write & sel_cfg & ~switch_busy;
  wire wr_int = reg_write & sel_int;
  wire wr_hrst = reg_write & sel_hrst;
  wire wr_lrst = reg_write & sel_lrst;
  wire rd_take = reg_read & ~cfg_stall;

  ////////////////////////////////////////////////////////////////////////////
  // control register one

  logic monitor_en_r;
  logic pll_en_r;
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic pll_en_nxt;
  logic failure_flag_r;

  wire [1:0] select_now =
    cfg_r[clock_ctrl_pkg::sys_clock_source_select_lsb +: 2];
  wire pll_in_use = (select_now == clock_ctrl_pkg::src_pll) |
                    (active_source == clock_ctrl_pkg::src_pll);
  wire ext_in_use = (active_source == clock_ctrl_pkg::src_fast_external) |
                    ((active_source == clock_ctrl_pkg::src_pll) &
                     cfg_r[clock_ctrl_pkg::pll_input_select_pos]);
  wire monitored_fail = fail_rise & monitor_en_r & ext_in_use;
  wire force_internal = wake_rise | entry_rise | monitored_fail; // RL5
  wire wr_pll_en = reg_wdata[clock_ctrl_pkg::pll_enable_bit_pos];

  always_comb begin
    pll_en_nxt = pll_en_r;
    if (wr_ctrl) begin
      if (wr_pll_en || !pll_in_use) begin
        pll_en_nxt = wr_pll_en; // RL2
      end
    end
    if (entry_rise ||
        (monitored_fail && cfg_r[clock_ctrl_pkg::pll_input_select_pos])) begin
      pll_en_nxt = 1'b0; // RL2
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      monitor_en_r <= 1'b0;
      pll_en_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        monitor_en_r <=
          reg_wdata[clock_ctrl_pkg::failure_monitor_enable_pos]; // RL1
      end
      pll_en_r <= pll_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register

  logic [31:0] cfg_masked;

  always_comb begin
    cfg_masked = (cfg_r & ~clock_ctrl_pkg::cfg_write_mask) |
                 (reg_wdata & clock_ctrl_pkg::cfg_write_mask);
    if (pll_en_r) begin
      // pll input and multiplier frozen while pll runs
      cfg_masked[clock_ctrl_pkg::pll_input_select_pos] =
        cfg_r[clock_ctrl_pkg::pll_input_select_pos]; // RL10
      cfg_masked[clock_ctrl_pkg::pll_external_input_divider_pos] =
        cfg_r[clock_ctrl_pkg::pll_external_input_divider_pos];
      cfg_masked[clock_ctrl_pkg::pll_multiplier_lsb +: 4] =
        cfg_r[clock_ctrl_pkg::pll_multiplier_lsb +: 4]; // RL11
    end
    cfg_nxt = wr_cfg ? cfg_masked : cfg_r;
    if (force_internal) begin
      cfg_nxt[clock_ctrl_pkg::sys_clock_source_select_lsb +: 2] =
        clock_ctrl_pkg::src_fast_internal; // RL5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_r <= clock_ctrl_pkg::reg_reset_value;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // reserved select code is held back from the switcher
  wire [1:0] switch_request = (select_now == clock_ctrl_pkg::src_unavailable) ?
                              active_source : select_now; // RL4

  clock_switch_seq u_switch (
    .clk_sys(clk_sys),
    .reset(reset),
    .request(switch_request),
    .active(active_source),
    .busy(switch_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // divider decode

  wire [3:0] ahb_code = cfg_r[clock_ctrl_pkg::ahb_divider_lsb +: 4];
  wire [2:0] apb_code = cfg_r[clock_ctrl_pkg::apb_divider_lsb +: 3];
  wire [3:0] mul_code = cfg_r[clock_ctrl_pkg::pll_multiplier_lsb +: 4];
  logic [8:0] ahb_div_nxt;

  always_comb begin
    case (ahb_code)
      4'h8: ahb_div_nxt = 9'h002;
      4'h9: ahb_div_nxt = 9'h004;
      4'ha: ahb_div_nxt = 9'h008;
      4'hb: ahb_div_nxt = 9'h010;
      4'hc: ahb_div_nxt = 9'h040;
      4'hd: ahb_div_nxt = 9'h080;
      4'he: ahb_div_nxt = 9'h100;
      4'hf: ahb_div_nxt = 9'h100;
      default: ahb_div_nxt = 9'h001;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ahb_divide_log2 <= 9'h001;
      apb_divide_log2 <= 5'h01;
      pll_factor <= 4'h2;
    end else begin
      ahb_divide_log2 <= ahb_div_nxt; // RL8
      apb_divide_log2 <= apb_code[2] ?
                         (5'h02 << apb_code[1:0]) : 5'h01; // RL9
      pll_factor <= (mul_code >= 4'he) ? 4'h0 : (mul_code + 4'h2); // RL11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tree_ctrl <= '0;
    end else begin
      tree_ctrl.pll_enable <= pll_en_r;
      tree_ctrl.pll_input_select <=
        cfg_r[clock_ctrl_pkg::pll_input_select_pos]; // RL10
      tree_ctrl.pll_external_input_divider <=
        cfg_r[clock_ctrl_pkg::pll_external_input_divider_pos];
      tree_ctrl.pll_multiplier <= mul_code;
      tree_ctrl.sys_clock_source <= active_source; // RL4
      tree_ctrl.ahb_divider <= ahb_code;
      tree_ctrl.apb_divider <= apb_code;
      tree_ctrl.converter_clock_divider <=
        cfg_r[clock_ctrl_pkg::converter_clock_divider_pos];
      tree_ctrl.clock_output_select <=
        cfg_r[clock_ctrl_pkg::clock_output_select_lsb +: 3]; // RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt register

  logic [5:0] irq_enable_r;
  wire [5:0] ready_flags;
  wire [5:0] clear_ready = wr_int ?
    reg_wdata[clock_ctrl_pkg::ready_clear_lsb +: 6] : 6'h00; // RL17
  wire clear_failure = wr_int &
    reg_wdata[clock_ctrl_pkg::clock_failure_clear_pos];

  ready_flag_bank u_flags (
    .clk_sys(clk_sys),
    .reset(reset),
    .ready_level(ready_sync),
    .irq_enable(irq_enable_r),
    .clear_pulse(clear_ready),
    .flag(ready_flags)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_enable_r <= 6'h00;
      failure_flag_r <= 1'b0;
      fail_prev_r <= 1'b0;
      entry_prev_r <= 1'b0;
      wake_prev_r <= 1'b0;
    end else begin
      fail_prev_r <= fail_sync;
      entry_prev_r <= entry_sync;
      wake_prev_r <= wake_sync;
      if (wr_int) begin
        irq_enable_r <=
          reg_wdata[clock_ctrl_pkg::ready_irq_enable_lsb +: 6]; // RL16
      end
      if (monitored_fail) begin
        failure_flag_r <= 1'b1; // RL15
      end else if (clear_failure) begin
        failure_flag_r <= 1'b0; // RL15
      end
    end
  end

  assign clock_irq = (|ready_flags) | failure_flag_r; // RL20
  assign nmi_request = failure_flag_r; // RL20

  ////////////////////////////////////////////////////////////////////////////
  // peripheral reset registers

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      apb_high_reset <= clock_ctrl_pkg::reg_reset_value;
      apb_low_reset <= clock_ctrl_pkg::reg_reset_value;
    end else begin
      if (wr_hrst) begin
        apb_high_reset <= reg_wdata &
                          clock_ctrl_pkg::apb_high_reset_mask; // RL18 RL22
      end
      if (wr_lrst) begin
        apb_low_reset <= reg_wdata &
                         clock_ctrl_pkg::apb_low_reset_mask; // RL19 RL22
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] ctrl_view;
  logic [31:0] cfg_view;
  logic [31:0] int_view;
  logic [31:0] rd_sel;

  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[clock_ctrl_pkg::failure_monitor_enable_pos] = monitor_en_r;
    ctrl_view[clock_ctrl_pkg::pll_enable_bit_pos] = pll_en_r;
    ctrl_view[clock_ctrl_pkg::pll_lock_flag_pos] = pll_locked; // RL3
    cfg_view = cfg_r & clock_ctrl_pkg::cfg_write_mask;
    cfg_view[clock_ctrl_pkg::sys_clock_source_status_lsb +: 2] =
      active_source; // RL6
    int_view = 32'h0000_0000;
    int_view[clock_ctrl_pkg::ready_flag_lsb +: 6] = ready_flags;
    int_view[clock_ctrl_pkg::clock_failure_flag_pos] = failure_flag_r;
    int_view[clock_ctrl_pkg::ready_irq_enable_lsb +: 6] = irq_enable_r;
    if (sel_ctrl) begin
      rd_sel = ctrl_view;
    end else if (sel_cfg) begin
      rd_sel = cfg_view;
    end else if (sel_int) begin
      rd_sel = int_view;
    end else if (sel_hrst) begin
      rd_sel = apb_high_reset;
    end else if (sel_lrst) begin
      rd_sel = apb_low_reset;
    end else begin
      rd_sel = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (rd_take) begin
      reg_rdata <= rd_sel;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : clock_config_interrupt_regs

// [verilog/clock_ctrl_pkg.sv]
// package: register map, field positions, reset values and codes of the
// clock configuration and interrupt register block.
// assumes a single 20 MHz system clock and a synchronous active-high reset.
package clock_ctrl_pkg;

  localparam int unsigned clk_period_ns = 50;

  // register byte offsets
  localparam logic [7:0] clock_control_one_offset = 8'h00;
  localparam logic [7:0] clock_configuration_one_offset = 8'h04;
  localparam logic [7:0] clock_interrupt_control_offset = 8'h08;
  localparam logic [7:0] apb_high_peripheral_reset_offset = 8'h0c;
  localparam logic [7:0] apb_low_peripheral_reset_offset = 8'h10;

  localparam logic [31:0] reg_reset_value = 32'h0000_0000;

  // clock control one fields
  localparam int unsigned failure_monitor_enable_pos = 19;
  localparam int unsigned pll_enable_bit_pos = 24;
  localparam int unsigned pll_lock_flag_pos = 25;

  // clock configuration one fields
  localparam int unsigned sys_clock_source_select_lsb = 0;
  localparam int unsigned sys_clock_source_status_lsb = 2;
  localparam int unsigned ahb_divider_lsb = 4;
  localparam int unsigned apb_divider_lsb = 8;
  localparam int unsigned converter_clock_divider_pos = 14;
  localparam int unsigned pll_input_select_pos = 16;
  localparam int unsigned pll_external_input_divider_pos = 17;
  localparam int unsigned pll_multiplier_lsb = 18;
  localparam int unsigned clock_output_select_lsb = 24;
  // writable bits of clock configuration one
  localparam logic [31:0] cfg_write_mask = 32'h07ff_47f3;

  // interrupt register fields
  localparam int unsigned ready_flag_lsb = 0;
  localparam int unsigned clock_failure_flag_pos = 7;
  localparam int unsigned ready_irq_enable_lsb = 8;
  localparam int unsigned ready_clear_lsb = 16;
  localparam int unsigned clock_failure_clear_pos = 23;
  localparam int unsigned ready_source_count = 6;

  // implemented peripheral reset bits
  localparam logic [31:0] apb_high_reset_mask = 32'h0041_5a01;
  localparam logic [31:0] apb_low_reset_mask = 32'h0000_0013;

  // clock switch stall: one or two cycles
  localparam logic [1:0] switch_wait_cycles = 2'h2;

  typedef enum logic [1:0] {
    src_fast_internal = 2'b00,
    src_fast_external = 2'b01,
    src_pll = 2'b10,
    src_unavailable = 2'b11
  } clock_source_type;

  // switch sequencer, gray coded except the done to idle step
  typedef enum logic [1:0] {
    sw_idle = 2'b00,
    sw_wait = 2'b01,
    sw_done = 2'b11
  } switch_state_type;

  // oscillator status from the analog side
  typedef struct packed {
    logic converter_osc_ready;
    logic pll_locked;
    logic fast_external_ready;
    logic fast_internal_ready;
    logic slow_external_ready;
    logic slow_internal_ready;
  } osc_status_type;

  // clock tree controls toward the analog side
  typedef struct packed {
    logic pll_enable;
    logic pll_input_select;
    logic pll_external_input_divider;
    logic [3:0] pll_multiplier;
    logic [1:0] sys_clock_source;
    logic [3:0] ahb_divider;
    logic [2:0] apb_divider;
    logic converter_clock_divider;
    logic [2:0] clock_output_select;
  } clock_tree_ctrl_type;

endpackage : clock_ctrl_pkg

// [verilog/ready_flag_bank.sv]
// ready flag bank: one sticky flag per oscillator source.
// assumes ready inputs are already synchronised to clk_sys.
`timescale 1ns/10ps
module ready_flag_bank (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [5:0] ready_level,
  input wire logic [5:0] irq_enable,
  input wire logic [5:0] clear_pulse,
  output logic [5:0] flag
);

  logic [5:0] ready_prev_r;
  logic [5:0] flag_r;

  assign flag = flag_r;

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_flag
      wire rise = ready_level[i] & ~ready_prev_r[i];
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          ready_prev_r[i] <= 1'b0;
          flag_r[i] <= 1'b0;
        end else begin
          ready_prev_r[i] <= ready_level[i];
          // set beats clear
          if (rise && irq_enable[i]) begin
            flag_r[i] <= 1'b1; // RL14
          end else if (clear_pulse[i]) begin
            flag_r[i] <= 1'b0; // RL17
          end
        end
      end
    end
  endgenerate

endmodule : ready_flag_bank

// [verilog/clock_switch_seq.sv]
// clock switch sequencer: follows a source request with a short stall.
// assumes request codes are valid sources only.
`timescale 1ns/10ps
module clock_switch_seq (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] request,
  output logic [1:0] active,
  output logic busy
);

  clock_ctrl_pkg::switch_state_type state_r;
  clock_ctrl_pkg::switch_state_type state_nxt;
  logic [1:0] active_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic [1:0] active_nxt;

  assign active = active_r;
  // stall only while waiting: an access sees at most two wait cycles
  assign busy = (state_r == clock_ctrl_pkg::sw_wait);

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    active_nxt = active_r;
    case (state_r)
      clock_ctrl_pkg::sw_idle: begin
        if (request != active_r) begin
          state_nxt = clock_ctrl_pkg::sw_wait;
          count_nxt = clock_ctrl_pkg::switch_wait_cycles - 2'h1;
        end
      end
      clock_ctrl_pkg::sw_wait: begin
        if (count_r == 2'h0) begin
          state_nxt = clock_ctrl_pkg::sw_done;
          active_nxt = request;
        end else begin
          count_nxt = count_r - 2'h1;
        end
      end
      default: begin
        state_nxt = clock_ctrl_pkg::sw_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= clock_ctrl_pkg::sw_idle;
      count_r <= 2'h0;
      active_r <= 2'b00;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      active_r <= active_nxt;
    end
  end

endmodule : clock_switch_seq

// [testbench/clk_cfg_assertions.sv]
// checker for the clock configuration and interrupt register block.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module clk_cfg_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_wait,
  input wire clock_ctrl_pkg::clock_tree_ctrl_type tree_ctrl,
  input wire logic [8:0] ahb_divide_log2,
  input wire logic [4:0] apb_divide_log2,
  input wire logic [3:0] pll_factor,
  input wire logic clock_irq,
  input wire logic nmi_request,
  input wire logic [31:0] apb_high_reset,
  input wire logic [31:0] apb_low_reset
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  function automatic logic [8:0] ahb_f(input logic [3:0] c);
    if (!c[3]) return 9'h001;
    if (c[2:0] > 3'h5) return 9'h100;
    if (c[2:0] > 3'h3) return 9'h004 << c[2:0];
    return 9'h002 << c[2:0];
  endfunction : ahb_f

  function automatic logic [3:0] pll_f(input logic [3:0] c);
    return (c > 4'hd) ? 4'h0 : c + 4'h2;
  endfunction : pll_f

  ////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_wait_cause: assert property (reg_wait |->
    reg_addr == 8'h04 && (reg_read || reg_write))
    else $error("wait without a configuration access");
  a_wait_short: assert property (reg_wait [*2] |=> !reg_wait)
    else $error("wait longer than two cycles");
  a_src_valid: assert property (tree_ctrl.sys_clock_source != 2'b11)
    else $error("unavailable clock source active");
  a_ahb_ratio: assert property ($stable(tree_ctrl.ahb_divider) |->
    ahb_divide_log2 == ahb_f(tree_ctrl.ahb_divider))
    else $error("ahb ratio wrong");
  a_apb_ratio: assert property ($stable(tree_ctrl.apb_divider) |->
    apb_divide_log2 == (tree_ctrl.apb_divider[2] ?
    5'h02 << tree_ctrl.apb_divider[1:0] : 5'h01))
    else $error("apb ratio wrong");
  a_pll_factor: assert property ($stable(tree_ctrl.pll_multiplier) |->
    pll_factor == pll_f(tree_ctrl.pll_multiplier))
    else $error("pll factor wrong");
  a_fail_forces: assert property ($rose(nmi_request) |->
    ##[0:4] tree_ctrl.sys_clock_source == 2'b00)
    else $error("no return to internal clock after failure");
  a_nmi_irq: assert property (nmi_request |-> clock_irq)
    else $error("nmi without clock interrupt");
  a_high_mask: assert property ((apb_high_reset & ~32'h0041_5a01) == 32'h0)
    else $error("reserved high reset bit set");
  a_low_mask: assert property ((apb_low_reset & ~32'h0000_0013) == 32'h0)
    else $error("reserved low reset bit set");
endmodule : clk_cfg_checker

// [testbench/tb_clock_config_interrupt_regs.sv]
// testbench for the clock configuration and interrupt register block.
// assumes a 20 MHz clock and one-cycle register strobes.
`timescale 1ns/10ps
module tb_clock_config_interrupt_regs;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_wait;
  clock_ctrl_pkg::osc_status_type osc_status = '0;
  logic fast_external_fail = 1'b0;
  logic low_power_entry = 1'b0;
  logic low_power_wake = 1'b0;
  clock_ctrl_pkg::clock_tree_ctrl_type tree_ctrl;
  logic [8:0] ahb_divide_log2;
  logic [4:0] apb_divide_log2;
  logic [3:0] pll_factor;
  logic clock_irq;
  logic nmi_request;
  logic [31:0] apb_high_reset;
  logic [31:0] apb_low_reset;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] v;

  always #25 clk_sys = ~clk_sys;

  clock_config_interrupt_regs uut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_wait(reg_wait), .osc_status(osc_status),
    .fast_external_fail(fast_external_fail),
    .low_power_entry(low_power_entry), .low_power_wake(low_power_wake),
    .tree_ctrl(tree_ctrl), .ahb_divide_log2(ahb_divide_log2),
    .apb_divide_log2(apb_divide_log2), .pll_factor(pll_factor),
    .clock_irq(clock_irq), .nmi_request(nmi_request),
    .apb_high_reset(apb_high_reset), .apb_low_reset(apb_low_reset));

  ////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    // one idle edge so a following write always re-raises the strobe
    @(posedge clk_sys);
  endtask : wr

  // answer is sampled mid-cycle, then the task ends on a rising edge
  task rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    chk($sformatf("register %h", a), e, reg_rdata);
    @(posedge clk_sys);
  endtask : rd

  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  function automatic logic [31:0] ahb_exp(input logic [3:0] c);
    if (!c[3]) return 32'h1;
    if (c[2:0] > 3'h5) return 32'h100;
    if (c[2:0] > 3'h3) return 32'h4 << c[2:0];
    return 32'h2 << c[2:0];
  endfunction : ahb_exp

  ////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0);
    chk("pll factor", 32'h2, 32'(pll_factor));
    wr(8'h00, 32'h0008_0000);
    rd(8'h00, 32'h0008_0000);
    $display("test reset and control done");
    for (int i = 0; i < 16; i++) begin
      v = 32'((i << 18) | ((i & 7) << 24) | (i << 4) | ((i & 7) << 8)
        | ((i & 1) << 14) | ((i & 1) << 17));
      wr(8'h04, v);
      repeat (2) @(posedge clk_sys);
      rd(8'h04, v);
      chk("ahb ratio", ahb_exp(v[7:4]), 32'(ahb_divide_log2));
      chk("apb ratio", v[10] ? 32'h2 << v[9:8] : 32'h1,
        32'(apb_divide_log2));
      chk("pll factor", (i > 13) ? 32'h0 : 32'(i + 2),
        32'(pll_factor));
      chk("output select", 32'(i & 7),
        32'(tree_ctrl.clock_output_select));
    end
    $display("test field codes done");
    osc_status <= 6'h10;
    wr(8'h04, 32'h0011_0000);
    wr(8'h00, 32'h0108_0000);
    repeat (6) @(posedge clk_sys);
    rd(8'h00, 32'h0308_0000);
    chk("pll enable", 32'h1, 32'(tree_ctrl.pll_enable));
    wr(8'h04, 32'h003c_0002);
    reg_addr <= 8'h04;
    reg_read <= 1'b1;
    @(negedge clk_sys);
    chk("wait", 32'h1, 32'(reg_wait));
    @(posedge clk_sys);
    reg_read <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(8'h04, 32'h0011_000a);
    chk("pll input", 32'h1, 32'(tree_ctrl.pll_input_select));
    chk("pll factor", 32'h6, 32'(pll_factor));
    wr(8'h00, 32'h0008_0000);
    rd(8'h00, 32'h0308_0000);
    osc_status <= 6'h00;
    low_power_entry <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(8'h00, 32'h0008_0000);
    chk("pll enable", 32'h0, 32'(tree_ctrl.pll_enable));
    rd(8'h04, 32'h0011_0000);
    low_power_entry <= 1'b0;
    low_power_wake <= 1'b1;
    $display("test pll and switch done");
    wr(8'h08, 32'h0000_1f00);
    osc_status <= 6'h3f;
    repeat (6) @(posedge clk_sys);
    rd(8'h08, 32'h0000_1f1f);
    chk("irq", 32'h1, 32'(clock_irq));
    wr(8'h08, 32'h0001_1f00);
    rd(8'h08, 32'h0000_1f1e);
    wr(8'h08, 32'h003e_1f00);
    rd(8'h08, 32'h0000_1f00);
    chk("irq", 32'h0, 32'(clock_irq));
    $display("test ready flags done");
    wr(8'h04, 32'h0000_0003);
    repeat (6) @(posedge clk_sys);
    rd(8'h04, 32'h0000_0003);
    wr(8'h04, 32'h0000_0001);
    repeat (6) @(posedge clk_sys);
    rd(8'h04, 32'h0000_0005);
    fast_external_fail <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("nmi", 32'h1, 32'(nmi_request));
    rd(8'h08, 32'h0000_1f80);
    rd(8'h04, 32'h0);
    wr(8'h08, 32'h0080_1f00);
    rd(8'h08, 32'h0000_1f00);
    chk("nmi", 32'h0, 32'(nmi_request));
    fast_external_fail <= 1'b0;
    $display("test clock failure done");
    wr(8'h0c, 32'hffff_ffff);
    wr(8'h10, 32'hffff_ffff);
    repeat (4) @(posedge clk_sys);
    rd(8'h0c, 32'h0041_5a01);
    rd(8'h10, 32'h0000_0013);
    chk("high resets", 32'h0041_5a01, apb_high_reset);
    chk("low resets", 32'h0000_0013, apb_low_reset);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("high resets", 32'h0, apb_high_reset);
    chk("low resets", 32'h0, apb_low_reset);
    $display("test peripheral resets done");
    end_sim();
  end
endmodule : tb_clock_config_interrupt_regs

bind clock_config_interrupt_regs clk_cfg_checker chk_i (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .reg_wait(reg_wait), .tree_ctrl(tree_ctrl),
  .ahb_divide_log2(ahb_divide_log2), .apb_divide_log2(apb_divide_log2),
  .pll_factor(pll_factor), .clock_irq(clock_irq),
  .nmi_request(nmi_request), .apb_high_reset(apb_high_reset),
  .apb_low_reset(apb_low_reset));
